// ==== uecr_regs.sv ====
// per-endpoint transfer count, interrupt enables, available count and response control
// assumes single-cycle register strobes and one-cycle event pulses from the packet engine
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module uecr_regs #(
	parameter int BUF_BYTES = uecr_pkg::BUF_BYTES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [uecr_pkg::ADDR_W-1:0] regAddr,
	input wire logic [uecr_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [uecr_pkg::DATA_W-1:0] regRdata,
	input wire logic epIsIn,
	input wire logic epIsZero,
	input wire logic epTypeInterrupt,
	input wire logic ctlReadDir,
	input wire logic statusPhase,
	input wire logic shortPktDone,
	input wire logic pktReceived,
	input wire logic pktSent,
	input wire logic pktAcked,
	input wire logic outTokenRcvd,
	input wire logic inTokenRcvd,
	input wire logic setupDetect,
	input wire logic inPktFull,
	input wire logic outBufEmptied,
	input wire logic bufWordWritten,
	input wire logic [1:0] bufReadBytes,
	input wire logic dmaRequestEnable,
	input wire logic [uecr_pkg::AVAIL_W-1:0] pageFill,
	input wire logic [uecr_pkg::AVAIL_W-1:0] dmaFill,
	output logic [uecr_pkg::IRQ_W-1:0] localIrqEvents,
	output logic localIrq,
	output logic [uecr_pkg::XFER_W-1:0] transferCount,
	output logic inValidate,
	output logic outRelease,
	output logic nakOutPackets,
	output logic statusNak,
	output logic statusAck,
	output logic statusZlp,
	output logic dataToggle,
	output logic endpointHalt,
	output logic retryDisable
);
	initial begin
		if (BUF_BYTES < 2 || BUF_BYTES > 2047) begin
			$error("BUF_BYTES out of range");
		end
	end
	localparam int VAL_CYC = uecr_pkg::VALIDATE_CYCLES;
	localparam logic [uecr_pkg::AVAIL_W-1:0] BUF_SIZE = uecr_pkg::AVAIL_W'(BUF_BYTES);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic [uecr_pkg::XFER_W-1:0] xfer_q;
	logic [uecr_pkg::XFER_W-1:0] xfer_d;
	logic [7:0] irqEn_q;
	logic [7:0] rsp_q;
	logic [7:0] rsp_d;
	logic [uecr_pkg::IRQ_W-1:0] irqEvt_q;
	logic [uecr_pkg::AVAIL_W-1:0] inEmpty_q;
	logic [7:0] rdata_q;
	logic release_q;
	logic timerDone;

	// register decode
	wire wrX0 = regWrite && hit(regAddr, uecr_pkg::OFF_XFER0);
	wire wrX1 = regWrite && hit(regAddr, uecr_pkg::OFF_XFER1);
	wire wrX2 = regWrite && hit(regAddr, uecr_pkg::OFF_XFER2);
	wire wrIrq = regWrite && hit(regAddr, uecr_pkg::OFF_IRQENB);
	wire wrClr = regWrite && hit(regAddr, uecr_pkg::OFF_RSPCLR);
	wire wrSet = regWrite && hit(regAddr, uecr_pkg::OFF_RSPSET);
	wire rdLow = regRead && hit(regAddr, uecr_pkg::OFF_AVAIL0);
	wire rdHigh = regRead && hit(regAddr, uecr_pkg::OFF_AVAIL1);
	wire [7:0] clrMask = wrClr ? regWdata : 8'h00;
	wire [7:0] setMask = wrSet ? regWdata : 8'h00;

	// response-control bits
	wire autoVal = rsp_q[uecr_pkg::RSP_AUTO_VALID];
	wire hideStatus = rsp_q[uecr_pkg::RSP_HIDE_STATUS];
	wire rateFb = rsp_q[uecr_pkg::RSP_RATE_FB] && epTypeInterrupt;
	wire ep0Setup = setupDetect && epIsZero;
	wire shortOut = shortPktDone && !epIsIn;
	wire altNakSet = shortOut && rsp_q[uecr_pkg::RSP_NAK_MODE];
	// rate feedback advances on every sent packet; normal mode only on a good handshake
	wire toggleAdv = rateFb ? pktSent : pktAcked;
	wire [7:0] hwSet = {altNakSet, 3'b000, ep0Setup, 3'b000};
	wire [7:0] hwClr = {7'b0000000, ep0Setup};

	always_comb begin
		// hardware sets and software sets both win over clears
		rsp_d = (rsp_q & ~clrMask & ~hwClr) | setMask | hwSet;
		rsp_d[uecr_pkg::RSP_TOGGLE] = rsp_d[uecr_pkg::RSP_TOGGLE] ^ toggleAdv;
	end

	// transfer counter
	wire upperZero = (xfer_q[23:8] == 16'h0000);
	wire valStart = wrX0 && (regWdata == 8'h00) && upperZero;
	wire altNakFall = rsp_q[uecr_pkg::RSP_ALT_NAK] && !rsp_d[uecr_pkg::RSP_ALT_NAK];
	wire [uecr_pkg::XFER_W-1:0] readInc = {22'h000000, bufReadBytes};

	always_comb begin
		xfer_d = xfer_q;
		if (!epIsIn && altNakFall) begin
			xfer_d = uecr_pkg::XFER_RESET;
		end else if (!epIsIn) begin
			xfer_d = xfer_q + readInc;
		end
		// a software write to a byte overrides the count of that byte
		if (wrX0) begin
			xfer_d[7:0] = regWdata;
		end
		if (wrX1) begin
			xfer_d[15:8] = regWdata;
		end
		if (wrX2) begin
			xfer_d[23:16] = regWdata;
		end
	end

	// validation and release
	wire validateNow = timerDone || (autoVal && inPktFull && epIsIn);
	wire manualRel = wrClr && regWdata[uecr_pkg::RSP_AUTO_VALID] && autoVal
		&& !setMask[uecr_pkg::RSP_AUTO_VALID];
	wire autoRel = autoVal && outBufEmptied && !epIsIn;

	uecr_validate_timer #(
		.CYCLES(VAL_CYC)
	) u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(valStart),
		.busy(),
		.done(timerDone)
	);

	// interrupt event gating
	wire statusHide = hideStatus && statusPhase;
	wire [uecr_pkg::IRQ_W-1:0] rawEvt = {shortPktDone, pktReceived && !statusHide,
		pktSent && !statusHide, outTokenRcvd, inTokenRcvd};
	wire [uecr_pkg::IRQ_W-1:0] gatedEvt = rawEvt & irqEn_q[uecr_pkg::IRQ_W-1:0];

	// available count
	wire [uecr_pkg::AVAIL_W-1:0] selFill = dmaRequestEnable ? dmaFill : pageFill;
	wire [uecr_pkg::AVAIL_W-1:0] emptyNow = BUF_SIZE - selFill;
	// IN count only moves when a whole word is written or a packet is validated, so software never sees half a word
	wire inRefresh = bufWordWritten || validateNow || !epIsIn;

	uecr_avail_if avIf ();
	assign avIf.liveCount = epIsIn ? inEmpty_q : selFill;
	assign avIf.lowRead = rdLow;
	assign avIf.highRead = rdHigh;

	uecr_avail_freeze u_freeze (
		.sys_clk(sys_clk),
		.rst(rst),
		.av(avIf.freeze)
	);

	// read mux
	wire [7:0] rdMux =
		hit(regAddr, uecr_pkg::OFF_XFER0) ? xfer_q[7:0] :
		hit(regAddr, uecr_pkg::OFF_XFER1) ? xfer_q[15:8] :
		hit(regAddr, uecr_pkg::OFF_XFER2) ? xfer_q[23:16] :
		hit(regAddr, uecr_pkg::OFF_IRQENB) ? irqEn_q :
		hit(regAddr, uecr_pkg::OFF_AVAIL0) ? avIf.shownCount[7:0] :
		hit(regAddr, uecr_pkg::OFF_AVAIL1) ? {5'b00000, avIf.shownCount[10:8]} :
		(hit(regAddr, uecr_pkg::OFF_RSPCLR) || hit(regAddr, uecr_pkg::OFF_RSPSET)) ? rsp_q :
		8'h00;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			xfer_q <= uecr_pkg::XFER_RESET;
			irqEn_q <= uecr_pkg::IRQENB_RESET;
			rsp_q <= uecr_pkg::RSP_RESET;
			irqEvt_q <= '0;
			inEmpty_q <= '0;
			rdata_q <= 8'h00;
			release_q <= 1'b0;
		end else begin
			xfer_q <= xfer_d;
			if (wrIrq) begin
				irqEn_q <= {3'b000, regWdata[uecr_pkg::IRQ_W-1:0]};
			end
			rsp_q <= rsp_d;
			irqEvt_q <= gatedEvt;
			if (inRefresh) begin
				inEmpty_q <= emptyNow;
			end
			rdata_q <= regRead ? rdMux : 8'h00;
			release_q <= manualRel || autoRel;
		end
	end

	assign regRdata = rdata_q;
	assign localIrqEvents = irqEvt_q;
	assign localIrq = |irqEvt_q;
	assign transferCount = xfer_q;
	assign inValidate = validateNow;
	assign outRelease = release_q;
	assign nakOutPackets = rsp_q[uecr_pkg::RSP_ALT_NAK];
	assign statusNak = rsp_q[uecr_pkg::RSP_STATUS_HOLD];
	assign statusAck = !rsp_q[uecr_pkg::RSP_STATUS_HOLD] && ctlReadDir;
	assign statusZlp = !rsp_q[uecr_pkg::RSP_STATUS_HOLD] && !ctlReadDir;
	assign dataToggle = rsp_q[uecr_pkg::RSP_TOGGLE];
	assign endpointHalt = rsp_q[uecr_pkg::RSP_HALT];
	assign retryDisable = rateFb;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_mid_readback: assert property (regRead && regAddr == uecr_pkg::OFF_XFER1
		|=> regRdata == $past(xfer_q[15:8]))
		else $error("transfer count byte 1 readback wrong");
	a_high_write: assert property (wrX2 |=> xfer_q[23:16] == $past(regWdata))
		else $error("transfer count byte 2 not written");
	a_short_irq: assert property (localIrqEvents[uecr_pkg::IRQ_SHORT]
		|-> $past(shortPktDone && irqEn_q[uecr_pkg::IRQ_SHORT]))
		else $error("short packet event without cause");
	a_rx_irq: assert property (pktReceived && irqEn_q[uecr_pkg::IRQ_RX] && !statusHide
		|=> localIrqEvents[uecr_pkg::IRQ_RX] && localIrq)
		else $error("received packet event lost");
	a_tx_hidden: assert property (pktSent && statusHide |=> !localIrqEvents[uecr_pkg::IRQ_TX])
		else $error("status phase event not hidden");
	a_irqenb_reserved: assert property (regRead && regAddr == uecr_pkg::OFF_IRQENB
		|=> regRdata[7:5] == 3'b000)
		else $error("reserved enable bits read nonzero");
	a_alt_nak: assert property (altNakSet |=> nakOutPackets)
		else $error("alt nak not set by short out");
	a_setup_ep0: assert property (ep0Setup && !setMask[uecr_pkg::RSP_HALT]
		|=> statusNak && !endpointHalt)
		else $error("setup did not hold status and clear halt");
	a_rate_toggle: assert property (pktSent && rateFb && !wrClr && !wrSet
		|=> dataToggle != $past(dataToggle))
		else $error("rate feedback toggle not advanced");
	a_validate_time: assert property (valStart && !u_timer.busy |-> ##VAL_CYC inValidate)
		else $error("validation latency wrong");
	a_rsp_reset: assert property (disable iff (1'b0) rst |=> rsp_q == uecr_pkg::RSP_RESET)
		else $error("response bits reset value wrong");
	a_avail_dma: assert property (!epIsIn && dmaRequestEnable |-> avIf.liveCount == dmaFill)
		else $error("dma count not selected");
	c_short_nak: cover property (altNakSet ##1 wrClr ##1 !nakOutPackets);
	c_validate: cover property (valStart ##[1:20] inValidate);
	c_freeze: cover property (rdLow ##[1:5] rdHigh);
	c_setup: cover property (ep0Setup ##[1:10] statusAck);
endmodule

// ==== uecr_pkg.sv ====
// constants shared by the endpoint response/control register slice
// assumes an 8-bit register port with byte offsets as printed
package uecr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int AVAIL_W = 11;
	localparam int AVAIL_HI_W = 3;
	localparam int XFER_W = 24;
	localparam int IRQ_W = 5;
	localparam logic [7:0] OFF_XFER0 = 8'h08;
	localparam logic [7:0] OFF_XFER1 = 8'h09;
	localparam logic [7:0] OFF_XFER2 = 8'h0A;
	localparam logic [7:0] OFF_IRQENB = 8'h0B;
	localparam logic [7:0] OFF_AVAIL0 = 8'h0C;
	localparam logic [7:0] OFF_AVAIL1 = 8'h0D;
	localparam logic [7:0] OFF_RSPCLR = 8'h0E;
	localparam logic [7:0] OFF_RSPSET = 8'h0F;
	// response-control bit positions
	localparam int RSP_ALT_NAK = 7;
	localparam int RSP_HIDE_STATUS = 6;
	localparam int RSP_AUTO_VALID = 5;
	localparam int RSP_RATE_FB = 4;
	localparam int RSP_STATUS_HOLD = 3;
	localparam int RSP_NAK_MODE = 2;
	localparam int RSP_TOGGLE = 1;
	localparam int RSP_HALT = 0;
	localparam logic [7:0] RSP_RESET = 8'h24;
	// interrupt-enable bit positions
	localparam int IRQ_SHORT = 4;
	localparam int IRQ_RX = 3;
	localparam int IRQ_TX = 2;
	localparam int IRQ_OUT_TOK = 1;
	localparam int IRQ_IN_TOK = 0;
	localparam logic [7:0] IRQENB_RESET = 8'h00;
	localparam logic [23:0] XFER_RESET = 24'h000000;
	localparam int BUF_BYTES = 1024;
	// validation latency
	localparam int CLK_PERIOD_NS = 8;
	localparam int VALIDATE_NS = 100;
	localparam int VALIDATE_CYCLES = (VALIDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [0:0] {
		VAL_IDLE = 1'b0,
		VAL_BUSY = 1'b1
	} uecr_val_state_t;
endpackage

// ==== uecr_avail_if.sv ====
// carries the live available count to the freeze logic and the shown value back
// assumes both ends share sys_clk
`timescale 1ns/1ns
interface uecr_avail_if;
	logic [uecr_pkg::AVAIL_W-1:0] liveCount;
	logic lowRead;
	logic highRead;
	logic [uecr_pkg::AVAIL_W-1:0] shownCount;
	modport regs (output liveCount, output lowRead, output highRead, input shownCount);
	modport freeze (input liveCount, input lowRead, input highRead, output shownCount);
endinterface

// ==== uecr_avail_freeze.sv ====
// snapshot of the available count taken on a low-byte read, dropped on a high-byte read
// assumes lowRead and highRead are one-cycle read strobes already decoded
`timescale 1ns/1ns
module uecr_avail_freeze (
	input wire logic sys_clk,
	input wire logic rst,
	uecr_avail_if.freeze av
);
	logic frozen_q;
	logic [uecr_pkg::AVAIL_W-1:0] snap_q;
	wire takeSnap = av.lowRead && !frozen_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frozen_q <= 1'b0;
			snap_q <= '0;
		end else begin
			if (takeSnap) begin
				snap_q <= av.liveCount;
			end
			// a high read releases even if a low read lands in the same cycle
			frozen_q <= av.highRead ? 1'b0 : (frozen_q || av.lowRead);
		end
	end

	assign av.shownCount = frozen_q ? snap_q : av.liveCount;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_freeze_holds: assert property (frozen_q && !av.highRead |=> av.shownCount == $past(av.shownCount))
		else $error("available count moved while frozen");
	a_high_releases: assert property (av.highRead |=> av.shownCount == av.liveCount)
		else $error("high read did not release freeze");
endmodule

// ==== uecr_validate_timer.sv ====
// stretches a validation request to the documented validation latency
// assumes start is a one-cycle pulse; starts while busy are absorbed
`timescale 1ns/1ns
module uecr_validate_timer #(
	parameter int CYCLES = uecr_pkg::VALIDATE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	output logic busy,
	output logic done
);
	initial begin
		if (CYCLES < 1 || CYCLES > 255) begin
			$error("CYCLES out of range");
		end
	end
	uecr_pkg::uecr_val_state_t state_q;
	uecr_pkg::uecr_val_state_t state_d;
	logic [7:0] cnt_q;
	localparam logic [7:0] LAST = 8'(CYCLES - 1);
	wire atEnd = (cnt_q == LAST);

	always_comb begin
		state_d = state_q;
		case (state_q)
			uecr_pkg::VAL_IDLE: begin
				if (start) begin
					state_d = uecr_pkg::VAL_BUSY;
				end
			end
			uecr_pkg::VAL_BUSY: begin
				if (atEnd) begin
					state_d = uecr_pkg::VAL_IDLE;
				end
			end
			default: state_d = uecr_pkg::VAL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= uecr_pkg::VAL_IDLE;
			cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_q == uecr_pkg::VAL_BUSY && !atEnd) ? cnt_q + 8'h01 : 8'h00;
		end
	end

	assign busy = (state_q == uecr_pkg::VAL_BUSY);
	// decoded from the last count so the pulse lands exactly CYCLES after the start edge
	assign done = (state_q == uecr_pkg::VAL_BUSY) && atEnd;
endmodule

// ==== uecr_cpu_model.sv ====
// local bus cpu model: drives the register port and scores read data
// assumes it sits inside uecr_regs_tb, whose chk task counts results
`timescale 1ns/1ns
module uecr_cpu_model (
	input wire logic sys_clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWrite,
	output logic regRead,
	input wire logic [7:0] regRdata
);
	logic [7:0] expQ[$];
	logic rdPend = 1'b0;
	initial begin
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// one idle edge between strobes so no signal is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(e);
		@(posedge sys_clk);
		regRead <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample exactly there
	always @(posedge sys_clk) begin
		if (rdPend && expQ.size() > 0)
			uecr_regs_tb.chk(regRdata, expQ.pop_front());
		rdPend <= regRead;
	end
endmodule

// ==== uecr_regs_tb.sv ====
// self-checking bench for the endpoint response/control register slice
// assumes uecr_cpu_model drives the register port; packet events come from here
`timescale 1ns/1ns
module uecr_regs_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic epIsIn = 1'b0, epIsZero = 1'b0, ctlReadDir = 1'b0, statusPhase = 1'b0;
	logic dmaEn = 1'b0;
	logic epTypeInt = 1'b0;
	logic retryDis;
	logic [6:0] ev = 7'h00;
	logic [10:0] pageFill = 11'h000, dmaFill = 11'h000, f, g;
	logic [7:0] regAddr, regWdata, regRdata;
	logic regWrite, regRead;
	logic [4:0] irqEv;
	logic [23:0] xferCnt, r;
	logic localIrq, inValidate, nakOut, statusNak, statusAck, statusZlp;
	int nErrors = 0, totalChecks = 0, cyc = 0, n;
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	uecr_cpu_model cpu (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
	uecr_regs dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .epIsIn(epIsIn),
		.epIsZero(epIsZero), .epTypeInterrupt(epTypeInt), .ctlReadDir(ctlReadDir),
		.statusPhase(statusPhase), .shortPktDone(ev[4]), .pktReceived(ev[3]),
		.pktSent(ev[2]), .pktAcked(ev[6]), .outTokenRcvd(ev[1]), .inTokenRcvd(ev[0]),
		.setupDetect(ev[5]), .inPktFull(1'b0), .outBufEmptied(1'b0),
		.bufWordWritten(1'b0), .bufReadBytes(2'b00), .dmaRequestEnable(dmaEn),
		.pageFill(pageFill), .dmaFill(dmaFill), .localIrqEvents(irqEv),
		.localIrq(localIrq), .transferCount(xferCnt), .inValidate(inValidate),
		.outRelease(), .nakOutPackets(nakOut), .statusNak(statusNak),
		.statusAck(statusAck), .statusZlp(statusZlp), .dataToggle(), .endpointHalt(),
		.retryDisable(retryDis));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nErrors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic pulse(input logic [6:0] e);
		@(posedge sys_clk);
		ev <= e;
		@(posedge sys_clk);
		ev <= 7'h00;
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ceiling well above the roughly 140 cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			nErrors++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'h3e74));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		cpu.rd(8'h09, 8'h00);
		cpu.rd(8'h0A, 8'h00);
		cpu.rd(8'h0B, 8'h00);
		cpu.rd(8'h0E, 8'h24);
		cpu.rd(8'h0F, 8'h24);
		r = 24'($urandom);
		cpu.wr(8'h09, r[7:0]);
		cpu.wr(8'h0A, r[15:8]);
		cpu.rd(8'h09, r[7:0]);
		cpu.rd(8'h0A, r[15:8]);
		chk(xferCnt, {r[15:0], 8'h00});
		cpu.wr(8'h0B, 8'hFF);
		cpu.rd(8'h0B, 8'h1F);
		// all five interrupt events fire at once so only the enabled one may pass
		for (int i = 0; i < 5; i++) begin
			cpu.wr(8'h0B, 8'(1 << i));
			pulse(7'h1F);
			chk(irqEv, 24'(1 << i));
			chk(localIrq, 1'b1);
		end
		cpu.rd(8'h0E, 8'hA4);
		chk(nakOut, 1'b1);
		cpu.wr(8'h0E, 8'h80);
		cpu.rd(8'h0F, 8'h24);
		cpu.wr(8'h0F, 8'h40);
		cpu.wr(8'h0B, 8'h0C);
		statusPhase <= 1'b1;
		pulse(7'h0C);
		chk(irqEv, 5'h00);
		statusPhase <= 1'b0;
		cpu.wr(8'h0E, 8'h40);
		pulse(7'h40);
		cpu.rd(8'h0E, 8'h26);
		cpu.wr(8'h0E, 8'h02);
		cpu.rd(8'h0E, 8'h24);
		// rate feedback: a sent packet alone advances the toggle
		epTypeInt <= 1'b1;
		cpu.wr(8'h0F, 8'h10);
		pulse(7'h04);
		chk(retryDis, 1'b1);
		cpu.rd(8'h0F, 8'h36);
		cpu.wr(8'h0E, 8'h12);
		epTypeInt <= 1'b0;
		cpu.rd(8'h0E, 8'h24);
		cpu.wr(8'h0F, 8'h01);
		cpu.rd(8'h0F, 8'h25);
		epIsZero <= 1'b1;
		pulse(7'h20);
		cpu.rd(8'h0E, 8'h2C);
		chk(statusNak, 1'b1);
		cpu.wr(8'h0E, 8'h08);
		ctlReadDir <= 1'b1;
		#10;
		chk({statusNak, statusAck}, 2'b01);
		ctlReadDir <= 1'b0;
		#10;
		chk(statusZlp, 1'b1);
		f = 11'($urandom_range(1024));
		g = 11'($urandom_range(1024));
		pageFill <= f;
		cpu.rd(8'h0C, f[7:0]);
		pageFill <= g;
		cpu.rd(8'h0D, {5'b0, f[10:8]});
		cpu.rd(8'h0D, {5'b0, g[10:8]});
		dmaEn <= 1'b1;
		dmaFill <= f;
		cpu.rd(8'h0C, f[7:0]);
		cpu.rd(8'h0D, {5'b0, f[10:8]});
		// manual validation: zero the upper bytes first, then the low byte
		epIsIn <= 1'b1;
		cpu.wr(8'h0E, 8'h20);
		cpu.wr(8'h09, 8'h00);
		cpu.wr(8'h0A, 8'h00);
		cpu.wr(8'h08, 8'h00);
		for (n = 1; n < 40; n++) begin
			#1;
			if (inValidate === 1'b1)
				break;
			@(posedge sys_clk);
		end
		chk(24'(n), 24'd13);
		cpu.rd(8'h20, 8'h00);
		repeat (3) @(posedge sys_clk);
		conclude();
	end
endmodule
